/* File: rtl/rgbr_map.svh */
`ifndef RGBR_MAP_SVH
`define RGBR_MAP_SVH

// Half-period lengths of the generated transmit clock, in mclk cycles
`define RGBR_HALF_W     3
`define RGBR_HALF_1000  3'h1
`define RGBR_HALF_100   3'h2
`define RGBR_HALF_10    3'h4

// Nibble positions inside a tile-side byte
`define RGBR_NIB_W      4
`define RGBR_NIB_LO     3:0
`define RGBR_NIB_HI     7:4
`define RGBR_BYTE_W     8

// Pin groups: transmit pins {clk, ctl, data[3:0]}, receive pins {ctl, data[3:0]}
`define RGBR_PIN_N      6
`define RGBR_GPI_N      5
`define RGBR_PIN_CTL    4
`define RGBR_PIN_CLK    5

// Synchroniser depths
`define RGBR_SYNC2_W    2
`define RGBR_SYNC3_W    3

`endif

/* File: rtl/rgbr_pkg.sv */
`include "rgbr_map.svh"

package rgbr_pkg;

   typedef enum logic [1:0] {
      RGBR_SPD_10   = 2'b00,
      RGBR_SPD_100  = 2'b01,
      RGBR_SPD_1000 = 2'b10
   } rgbr_speed_type;

   typedef enum logic {
      RGBR_NIB_LO = 1'b0,
      RGBR_NIB_HI = 1'b1
   } rgbr_nib_type;

   typedef struct packed {
      logic [`RGBR_BYTE_W-1:0] data;
      logic                    valid;
      logic                    err;
   } rgbr_word_type;

   typedef struct packed {
      logic [`RGBR_HALF_W-1:0]  tick;
      logic                     clk;
      rgbr_nib_type             nib;
      rgbr_speed_type           speed;
      rgbr_word_type            hold;
      rgbr_word_type            cur;
      logic                     txReady;
      logic [`RGBR_NIB_W-1:0]   transmit_word_port;
      logic                     txCtl;
      logic                     txClk;
      logic [`RGBR_PIN_N-1:0]   pinOe;
      logic [`RGBR_GPI_N-1:0]   gpiMeta;
      logic [`RGBR_GPI_N-1:0]   gpiSync;
      logic [`RGBR_GPI_N-1:0]   gpiOut;
      logic [`RGBR_SYNC3_W-1:0] reqSync;
      logic [`RGBR_SYNC3_W-1:0] dropSync;
      logic [`RGBR_SYNC2_W-1:0] dvSync;
      logic                     ackT;
      rgbr_word_type            rxOut;
      logic                     rxStrobe;
      logic                     rxOverrun;
   } rgbr_main_type;

   typedef struct packed {
      logic [`RGBR_SYNC2_W-1:0] rstSync;
      logic [`RGBR_SYNC2_W-1:0] enSync;
      logic [`RGBR_SYNC2_W-1:0] ackSync;
      rgbr_speed_type           spdMeta;
      rgbr_speed_type           spdSync;
      logic [`RGBR_NIB_W-1:0]   riseNib;
      logic                     riseCtl;
      rgbr_nib_type             nib;
      logic [`RGBR_NIB_W-1:0]   lowNib;
      rgbr_word_type            word;
      logic                     reqT;
      logic                     dropT;
      logic                     dv;
   } rgbr_rx_type;

   function automatic logic rgbr_is_gig(input rgbr_speed_type s);
      return s == RGBR_SPD_1000;
   endfunction : rgbr_is_gig

endpackage : rgbr_pkg

/* File: rtl/rgbr_ddr_rx.sv */
`timescale 1ns/1ps
`include "rgbr_map.svh"

module rgbr_ddr_rx
   import rgbr_pkg::*;
(
   input  wire logic                   rxClk,
   input  wire logic                   rst,
   input  wire logic                   enable,
   input  wire rgbr_speed_type         speed,
   input  wire logic                   ackT,
   input  wire logic [`RGBR_NIB_W-1:0] rxDataPin,
   input  wire logic                   rxCtlPin,
   output rgbr_word_type               rxWord,
   output logic                        reqT,
   output logic                        dropT,
   output logic                        rxDv
);

   rgbr_rx_type             st;
   rgbr_rx_type             next_st;
   logic [`RGBR_NIB_W-1:0]  fallNib;
   logic                    fallCtl;
   logic                    dvNow;
   logic                    erNow;
   logic                    done;
   logic [`RGBR_BYTE_W-1:0] byteNow;

   // Falling-edge half of each DDR pair; read on the following rising edge
   always_ff @(negedge rxClk) begin
      fallNib <= rxDataPin;
      fallCtl <= rxCtlPin;
   end

   always_comb begin
      next_st         = st;
      next_st.rstSync = {st.rstSync[0], rst};
      next_st.enSync  = {st.enSync[0], enable};
      next_st.ackSync = {st.ackSync[0], ackT};
      next_st.spdMeta = speed;
      next_st.spdSync = st.spdMeta;
      next_st.riseNib = rxDataPin;
      next_st.riseCtl = rxCtlPin;
      dvNow           = st.riseCtl;
      erNow           = st.riseCtl ^ fallCtl;
      next_st.dv      = dvNow;
      done            = 1'b0;
      byteNow         = '0;
      if (rgbr_is_gig(st.spdSync)) begin
         done    = 1'b1;
         byteNow = {fallNib, st.riseNib};
      end else if (!dvNow) begin
         next_st.nib = RGBR_NIB_LO;
      end else if (st.nib == RGBR_NIB_LO) begin
         next_st.lowNib = st.riseNib;
         next_st.nib    = RGBR_NIB_HI;
      end else begin
         done        = 1'b1;
         byteNow     = {st.riseNib, st.lowNib};
         next_st.nib = RGBR_NIB_LO;
      end
      // Word is only rewritten once the tile side has acknowledged the last one
      if (done && st.enSync[1] && (dvNow || erNow)) begin
         if (st.ackSync[1] == st.reqT) begin
            next_st.word.data  = byteNow;
            next_st.word.valid = dvNow;
            next_st.word.err   = erNow;
            next_st.reqT       = !st.reqT;
         end else begin
            next_st.dropT = !st.dropT;
         end
      end
      // Reset needs receive clock edges; the PHY keeps this clock running meanwhile
      if (st.rstSync[1]) begin
         next_st         = '0;
         next_st.rstSync = {st.rstSync[0], rst};
      end
   end

   always_ff @(posedge rxClk) begin
      st <= next_st;
   end

   assign rxWord = st.word;
   assign reqT   = st.reqT;
   assign dropT  = st.dropT;
   assign rxDv   = st.dv;

   AST_RX_HANDOFF: assert property (@(posedge rxClk) disable iff (st.rstSync[1])
      $changed(st.reqT) |-> ($past(st.ackSync[1]) != st.reqT))
      else $error("receive word replaced before acknowledge");

   AST_RX_SPLIT: assert property (@(posedge rxClk) disable iff (st.rstSync[1])
      $changed(st.reqT) && rgbr_is_gig(st.spdSync) && $stable(st.spdSync)
      |-> (st.word.valid == $past(st.riseCtl)))
      else $error("receive valid not taken from rising-edge control");

endmodule : rgbr_ddr_rx

/* File: rtl/rgbr_bridge.sv */
`timescale 1ns/1ps
`include "rgbr_map.svh"
// Notes on behaviour
// - With the gasket enabled its pins leave general-purpose use and are driven by the gasket.
// - While enabled, the tile ports and gasket pins serve only the gasket; others are untouched.
// - The gasket makes the transmit clock and can delay its edge against the transmit data.
// - Four DDR data wires plus one control wire convert to eight SDR bits plus two controls.
// - Transmit, receive and clock-delay paths have own timing; speed changes only when idle.

module rgbr_bridge
   import rgbr_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   rxClk,
   input  wire logic                   gasketEn,
   input  wire rgbr_speed_type         speedSel,
   input  wire logic                   txClkDelay,
   input  wire rgbr_word_type          txIn,
   input  wire logic [`RGBR_PIN_N-1:0] gpioOut,
   input  wire logic [`RGBR_PIN_N-1:0] gpioOe,
   input  wire logic [`RGBR_NIB_W-1:0] rxDataPin,
   input  wire logic                   rxCtlPin,
   output logic                        txReady,
   output rgbr_word_type               rxOut,
   output logic                        rxStrobe,
   output logic                        rxOverrun,
   output rgbr_speed_type              speedActive,
   output logic [`RGBR_NIB_W-1:0]      txDataPin,
   output logic                        txCtlPin,
   output logic                        txClkPin,
   output logic [`RGBR_PIN_N-1:0]      txPinOe,
   output logic [`RGBR_GPI_N-1:0]      gpioIn
);

   rgbr_main_type           st;
   rgbr_main_type           next_st;
   rgbr_word_type           rxWord;
   logic                    reqT;
   logic                    dropT;
   logic                    rxDv;
   logic                    halfEnd;
   logic                    spdChange;
   logic                    loadNow;

   function automatic logic [`RGBR_HALF_W-1:0] rgbr_half(input rgbr_speed_type s);
      case (s)
         RGBR_SPD_1000: return `RGBR_HALF_1000;
         RGBR_SPD_100:  return `RGBR_HALF_100;
         RGBR_SPD_10:   return `RGBR_HALF_10;
         default:       return `RGBR_HALF_10;
      endcase
   endfunction : rgbr_half

   // Receive capture lives on the PHY's clock; only toggles and levels cross back
   rgbr_ddr_rx u_rx (
      .rxClk     (rxClk),
      .rst       (rst),
      .enable    (gasketEn),
      .speed     (st.speed),
      .ackT      (st.ackT),
      .rxDataPin (rxDataPin),
      .rxCtlPin  (rxCtlPin),
      .rxWord    (rxWord),
      .reqT      (reqT),
      .dropT     (dropT),
      .rxDv      (rxDv)
   );

   always_comb begin
      next_st   = st;
      halfEnd   = (st.tick == rgbr_half(st.speed) - `RGBR_HALF_W'(1));
      loadNow   = halfEnd && !st.clk &&
                  (rgbr_is_gig(st.speed) || st.nib == RGBR_NIB_LO);
      // Speed follows the request only while both directions are idle
      spdChange = gasketEn && !st.dvSync[1] && !st.cur.valid && !st.hold.valid &&
                  (speedSel != st.speed);

      // Receive pins as general-purpose inputs: pins are asynchronous here
      next_st.gpiMeta  = {rxCtlPin, rxDataPin};
      next_st.gpiSync  = st.gpiMeta;
      next_st.gpiOut   = gasketEn ? '0 : st.gpiSync;

      // Receive word handoff from the PHY clock domain
      next_st.reqSync  = {st.reqSync[1:0], reqT};
      next_st.dropSync = {st.dropSync[1:0], dropT};
      next_st.dvSync   = {st.dvSync[0], rxDv};
      next_st.rxStrobe = 1'b0;
      next_st.rxOverrun = gasketEn && (st.dropSync[2] != st.dropSync[1]);
      if (st.reqSync[2] != st.reqSync[1]) begin
         // Acknowledge even when disabled so the receive side never locks up
         next_st.ackT     = st.reqSync[1];
         next_st.rxOut    = rxWord;
         next_st.rxStrobe = gasketEn;
      end

      if (!gasketEn) begin
         // Pins fall back to general-purpose use
         next_st.tick    = '0;
         next_st.clk     = 1'b0;
         next_st.nib     = RGBR_NIB_LO;
         next_st.hold    = '0;
         next_st.cur     = '0;
         next_st.txReady = 1'b0;
         next_st.transmit_word_port  = gpioOut[`RGBR_NIB_W-1:0];
         next_st.txCtl   = gpioOut[`RGBR_PIN_CTL];
         next_st.txClk   = gpioOut[`RGBR_PIN_CLK];
         next_st.pinOe   = gpioOe;
      end else begin
         next_st.pinOe = '1;
         if (halfEnd) begin
            next_st.tick = '0;
            next_st.clk  = !st.clk;
            if (!st.clk) begin
               if (loadNow) begin
                  // Idle cycles go out as a zero word with valid low
                  next_st.cur    = st.hold.valid ? st.hold : '0;
                  next_st.hold   = '0;
                  next_st.transmit_word_port = next_st.cur.data[`RGBR_NIB_LO];
                  next_st.txCtl  = next_st.cur.valid;
                  next_st.nib    = RGBR_NIB_HI;
               end else begin
                  next_st.transmit_word_port = st.cur.data[`RGBR_NIB_HI];
                  next_st.txCtl  = st.cur.valid;
                  next_st.nib    = RGBR_NIB_LO;
               end
            end else begin
               next_st.txCtl = st.cur.valid ^ st.cur.err;
               if (rgbr_is_gig(st.speed)) begin
                  next_st.transmit_word_port = st.cur.data[`RGBR_NIB_HI];
                  next_st.nib    = RGBR_NIB_LO;
               end
            end
         end else begin
            next_st.tick = st.tick + `RGBR_HALF_W'(1);
         end
         // One-word holding stage; ready reflects room in it
         if (st.txReady && txIn.valid) begin
            next_st.hold = txIn;
         end
         if (spdChange) begin
            next_st.speed = speedSel;
            next_st.tick  = '0;
            next_st.clk   = 1'b0;
            next_st.nib   = RGBR_NIB_LO;
         end
         next_st.txReady = !next_st.hold.valid;
         // Delayed option re-times the clock by one mclk, half a gigabit period
         next_st.txClk   = txClkDelay ? st.clk : next_st.clk;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign txReady     = st.txReady;
   assign rxOut       = st.rxOut;
   assign rxStrobe    = st.rxStrobe;
   assign rxOverrun   = st.rxOverrun;
   assign speedActive = st.speed;
   assign txDataPin   = st.transmit_word_port;
   assign txCtlPin    = st.txCtl;
   assign txClkPin    = st.txClk;
   assign txPinOe     = st.pinOe;
   assign gpioIn      = st.gpiOut;

   AST_GPIO_PASS: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> (txPinOe == $past(gpioOe)) &&
                    (txDataPin == $past(gpioOut[`RGBR_NIB_W-1:0])))
      else $error("general-purpose drive not passed while gasket off");

   AST_PINS_OWNED: assert property (@(posedge mclk) disable iff (rst)
      gasketEn |=> (txPinOe == '1))
      else $error("gasket pins not all driven while enabled");

   AST_TILE_QUIET: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> !txReady && !rxStrobe)
      else $error("tile ports active while gasket off");

   AST_GPIO_MASKED: assert property (@(posedge mclk) disable iff (rst)
      gasketEn ##1 gasketEn |=> (gpioIn == '0))
      else $error("receive pins still seen as general-purpose inputs");

   AST_CLK_GIG: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && rgbr_is_gig(st.speed) && !spdChange |=> (st.clk != $past(st.clk)))
      else $error("gigabit transmit clock did not toggle");

   AST_CLK_DELAY: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && txClkDelay |=> (txClkPin == $past(st.clk)))
      else $error("delayed transmit clock not one cycle late");

   AST_CTL_RISE: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && loadNow |=> (txCtlPin == st.cur.valid) &&
                              (txDataPin == st.cur.data[`RGBR_NIB_LO]))
      else $error("rising half does not carry valid and low nibble");

   AST_CTL_FALL: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && halfEnd && st.clk |=> (txCtlPin == (st.cur.valid ^ st.cur.err)))
      else $error("falling half does not carry valid xor error");

   AST_SPEED_IDLE: assert property (@(posedge mclk) disable iff (rst)
      $changed(st.speed) |-> ($past(st.dvSync[1]) == 1'b0) && ($past(st.cur.valid) == 1'b0))
      else $error("speed changed while a frame was active");

   AST_RX_STROBE: assert property (@(posedge mclk) disable iff (rst)
      rxStrobe |-> $past(gasketEn) ##1 !rxStrobe [*2])
      else $error("receive strobes closer than the handshake allows");

   AST_READY_FALL: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && txReady && txIn.valid |=> !txReady)
      else $error("ready stayed high after a word was taken");

   AST_HOLD_LOAD: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && txReady && txIn.valid |=> (st.hold == $past(txIn)))
      else $error("pushed word not held");

   AST_READY_EMPTY: assert property (@(posedge mclk) disable iff (rst)
      gasketEn |=> (txReady == !st.hold.valid))
      else $error("ready does not reflect room in the holding stage");

   AST_HOLD_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && loadNow && st.hold.valid |=> (st.cur == $past(st.hold)))
      else $error("held word not moved to the line");

   AST_TX_LOAD_IDLE: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && loadNow && !st.hold.valid |=> !txCtlPin)
      else $error("idle period shows valid on the control wire");

   AST_NIB_GIG: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && rgbr_is_gig(st.speed) && halfEnd && st.clk && !spdChange
      |=> (txDataPin == $past(st.cur.data[`RGBR_NIB_HI])))
      else $error("gigabit falling half does not carry high nibble");

   AST_SLOW_HI: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && !rgbr_is_gig(st.speed) && halfEnd && !st.clk && !loadNow
      |=> (txDataPin == $past(st.cur.data[`RGBR_NIB_HI])))
      else $error("second slow period does not carry high nibble");

   AST_SLOW_FALL_HOLD: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && !rgbr_is_gig(st.speed) && halfEnd && st.clk |=> $stable(txDataPin))
      else $error("slow nibble changed within its period");

   AST_TICK_RANGE: assert property (@(posedge mclk) disable iff (rst)
      gasketEn |-> (st.tick < rgbr_half(st.speed)))
      else $error("half-period counter beyond its end");

   AST_TICK_HOLD: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && !halfEnd && !spdChange |=> $stable(st.clk))
      else $error("transmit clock moved inside a half period");

   AST_CLK_DIRECT: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && !txClkDelay |=> (txClkPin == st.clk))
      else $error("undelayed transmit clock not in step");

   AST_CTL_PASS: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> (txCtlPin == $past(gpioOut[`RGBR_PIN_CTL])) &&
                    (txClkPin == $past(gpioOut[`RGBR_PIN_CLK])))
      else $error("general-purpose drive of clock or control pin lost");

   AST_GPIO_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> (gpioIn == $past(st.gpiSync)))
      else $error("receive pins not seen as general-purpose inputs");

   AST_IDLE_TX: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> !st.cur.valid && !st.hold.valid)
      else $error("transmit path busy while gasket off");

   AST_OVR_OFF: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> !rxOverrun)
      else $error("overrun reported while gasket off");

   AST_SPEED_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !gasketEn |=> $stable(st.speed))
      else $error("speed changed while gasket off");

   AST_DV_SPEED: assert property (@(posedge mclk) disable iff (rst)
      gasketEn && st.dvSync[1] |=> $stable(st.speed))
      else $error("speed changed during a receive frame");

   AST_SPEED_TAKE: assert property (@(posedge mclk) disable iff (rst)
      $changed(st.speed) |-> (st.speed == $past(speedSel)))
      else $error("speed in force differs from the request");

   AST_RX_OUT: assert property (@(posedge mclk) disable iff (rst)
      rxStrobe |-> (rxOut == $past(rxWord)))
      else $error("receive word not taken with its strobe");

   AST_STROBE_CAUSE: assert property (@(posedge mclk) disable iff (rst)
      rxStrobe |-> $past(st.reqSync[2] != st.reqSync[1]))
      else $error("receive strobe without a request");

   AST_OVR_CAUSE: assert property (@(posedge mclk) disable iff (rst)
      rxOverrun |-> $past(st.dropSync[2] != st.dropSync[1]))
      else $error("overrun without a dropped word");

   AST_RX_ACK: assert property (@(posedge mclk) disable iff (rst)
      (st.reqSync[2] != st.reqSync[1]) |=> (st.ackT == $past(st.reqSync[1])))
      else $error("receive request not acknowledged");

endmodule : rgbr_bridge

/* File: tb/rgbr_phy_model.sv */
`timescale 1ns/1ps
`include "rgbr_map.svh"

module rgbr_phy_model
   import rgbr_pkg::*;
(
   output logic                   rxClk,
   output logic [`RGBR_NIB_W-1:0] rxDataPin,
   output logic                   rxCtlPin
);

   // The clock stays low at power-up, then runs so the receive side can clear in reset
   initial begin
      rxClk     = 1'h0;
      rxDataPin = 4'h0;
      rxCtlPin  = 1'h0;
      #20;
      forever #15 rxClk = ~rxClk;
   end

   // Lines change mid-way between edges so both edges see settled values
   task automatic put(input logic [`RGBR_NIB_W-1:0] nib, input logic ctl);
      #7;
      rxDataPin = nib;
      rxCtlPin  = ctl;
   endtask : put

   // Low nibble with valid at the rise, high nibble with valid xor error at the fall
   task automatic send_byte(input rgbr_word_type w);
      @(negedge rxClk);
      put(w.data[`RGBR_NIB_LO], w.valid);
      @(posedge rxClk);
      put(w.data[`RGBR_NIB_HI], w.valid ^ w.err);
   endtask : send_byte

   // Between frames the data keeps changing so a stale nibble can never pass for a fresh one
   task automatic idle(input int halves);
      repeat (halves) begin
         @(rxClk);
         put(~rxDataPin, 1'h0);
      end
   endtask : idle

   task automatic park(input logic [`RGBR_GPI_N-1:0] pins);
      rxCtlPin  = pins[`RGBR_PIN_CTL];
      rxDataPin = pins[`RGBR_NIB_LO];
   endtask : park

endmodule : rgbr_phy_model

/* File: tb/rgbr_bridge_tb.sv */
`timescale 1ns/1ps
`include "rgbr_map.svh"

`define RGBR_CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin mismatches++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, act, exp); end end

module rgbr_bridge_tb
   import rgbr_pkg::*;
;

   logic                     mclk;
   logic                     rst;
   logic                     rxClk;
   logic                     gasketEn;
   rgbr_speed_type           speedSel;
   logic                     txClkDelay;
   rgbr_word_type            txIn;
   logic [`RGBR_PIN_N-1:0]   gpioOut;
   logic [`RGBR_PIN_N-1:0]   gpioOe;
   logic [`RGBR_NIB_W-1:0]   rxDataPin;
   logic                     rxCtlPin;
   logic                     txReady;
   rgbr_word_type            rxOut;
   logic                     rxStrobe;
   logic                     rxOverrun;
   rgbr_speed_type           speedActive;
   logic [`RGBR_NIB_W-1:0]   txDataPin;
   logic                     txCtlPin;
   logic                     txClkPin;
   logic [`RGBR_PIN_N-1:0]   txPinOe;
   logic [`RGBR_GPI_N-1:0]   gpioIn;
   int                       mismatches = 0;
   int                       testsRun = 0;

   rgbr_bridge DUT (
      .mclk(mclk), .rst(rst), .rxClk(rxClk), .gasketEn(gasketEn), .speedSel(speedSel),
      .txClkDelay(txClkDelay), .txIn(txIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .rxDataPin(rxDataPin), .rxCtlPin(rxCtlPin), .txReady(txReady), .rxOut(rxOut),
      .rxStrobe(rxStrobe), .rxOverrun(rxOverrun), .speedActive(speedActive),
      .txDataPin(txDataPin), .txCtlPin(txCtlPin), .txClkPin(txClkPin),
      .txPinOe(txPinOe), .gpioIn(gpioIn)
   );

   rgbr_phy_model phy (
      .rxClk(rxClk), .rxDataPin(rxDataPin), .rxCtlPin(rxCtlPin)
   );

   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic reset_case();
      int n;
      n = 0;
      @(negedge mclk);
      `RGBR_CHK(txReady, 1'h0)
      `RGBR_CHK(speedActive, RGBR_SPD_10)
      do @(negedge mclk); while (txReady !== 1'h1 && ++n < 4);
      `RGBR_CHK(txReady, 1'h1)
   endtask : reset_case

   // One byte out, checked nibble by nibble against the clock phase
   task automatic tx_case(input logic [7:0] d, input logic e, input logic dly);
      int n;
      n = 0;
      @(posedge mclk);
      txClkDelay <= dly;
      do @(negedge mclk); while (txReady !== 1'h1 && ++n < 20);
      @(posedge mclk);
      txIn <= {d, 1'h1, e};
      @(posedge mclk);
      txIn.valid <= 1'h0;
      @(negedge mclk);
      `RGBR_CHK(txReady, 1'h0)
      n = 0;
      do @(negedge mclk); while (txCtlPin !== 1'h1 && ++n < 20);
      `RGBR_CHK(txDataPin, d[3:0])
      `RGBR_CHK(txClkPin, ~dly)
      @(negedge mclk);
      `RGBR_CHK(txDataPin, d[7:4])
      `RGBR_CHK(txCtlPin, ~e)
      `RGBR_CHK(txClkPin, dly)
   endtask : tx_case

   task automatic gpio_case();
      @(posedge mclk);
      gasketEn <= 1'h0;
      gpioOut  <= 6'h2A;
      gpioOe   <= 6'h15;
      phy.park(5'h1B);
      repeat (5) @(negedge mclk);
      `RGBR_CHK({txClkPin, txCtlPin, txDataPin}, 6'h2A)
      `RGBR_CHK(txPinOe, 6'h15)
      `RGBR_CHK(gpioIn, 5'h1B)
      `RGBR_CHK(txReady, 1'h0)
      phy.idle(2);
      @(posedge mclk);
      gasketEn <= 1'h1;
      repeat (2) @(negedge mclk);
      `RGBR_CHK(txPinOe, 6'h3F)
      repeat (4) @(negedge mclk);
      `RGBR_CHK(gpioIn, 5'h00)
   endtask : gpio_case

   // Sends n copies back to back; the handshake is slower than the link, so extras drop
   task automatic rx_case(input rgbr_word_type w, input int n, input int expStb,
                          input logic expOvr);
      int            stb;
      logic          ovr;
      rgbr_word_type got;
      stb = 0;
      ovr = 1'h0;
      got = '0;
      fork
         begin
            repeat (n) phy.send_byte(w);
            phy.idle(4);
         end
         repeat (40) begin
            @(negedge mclk);
            if (rxStrobe === 1'h1) begin
               stb++;
               got = rxOut;
            end
            if (rxOverrun === 1'h1) ovr = 1'h1;
         end
      join
      `RGBR_CHK(stb, expStb)
      if (expStb > 0) `RGBR_CHK(got, w)
      `RGBR_CHK(ovr, expOvr)
   endtask : rx_case

   task automatic speed_case(input rgbr_speed_type s);
      int n;
      n = 0;
      @(posedge mclk);
      speedSel <= s;
      do @(negedge mclk); while (speedActive !== s && ++n < 30);
      `RGBR_CHK(speedActive, s)
   endtask : speed_case

   initial begin
      rst        = 1'h1;
      gasketEn   = 1'h1;
      speedSel   = RGBR_SPD_1000;
      txClkDelay = 1'h0;
      txIn       = '0;
      gpioOut    = 6'h00;
      gpioOe     = 6'h00;
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      reset_case();
      tx_case(8'h3C, 1'h0, 1'h0);
      tx_case(8'hA5, 1'h1, 1'h1);
      gpio_case();
      rx_case({8'h5A, 1'h1, 1'h0}, 1, 1, 1'h0);
      rx_case({8'hC3, 1'h1, 1'h1}, 1, 1, 1'h0);
      rx_case({8'h77, 1'h0, 1'h0}, 1, 0, 1'h0);
      rx_case({8'h96, 1'h1, 1'h0}, 2, 1, 1'h1);
      speed_case(RGBR_SPD_10);
      speed_case(RGBR_SPD_100);
      speed_case(RGBR_SPD_1000);
      end_of_test();
   end

   // The whole sequence needs well under a tenth of this span
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end

endmodule : rgbr_bridge_tb
